// File: design/timer2_params.svh
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define T2_OFS_CTRL_A      12'h0B0
`define T2_OFS_CTRL_B      12'h0B4
`define T2_OFS_COUNT       12'h0B8
`define T2_OFS_CMP_A       12'h0BC
`define T2_OFS_CMP_B       12'h0C0
`define T2_OFS_STATUS      12'h0C4
`define T2_OFS_GENERAL     12'h0C8
`define T2_OFS_FLAGS       12'h0CC

// ==========================================================================
// Reset values and counter limits
`define T2_RST_BYTE        8'h00
`define T2_RST_WORD        32'h0000_0000
`define T2_MAX             8'hFF
`define T2_BOTTOM          8'h00

// ==========================================================================
// Field positions
`define T2_COM_A_HI        7
`define T2_COM_A_LO        6
`define T2_WAVE_BIT2       3
`define T2_CS_HI           2
`define T2_ST_ASYNC        5
`define T2_ST_CNT_BUSY     4
`define T2_ST_CMPA_BUSY    3
`define T2_ST_CMPB_BUSY    2
`define T2_ST_CTLA_BUSY    1
`define T2_ST_CTLB_BUSY    0
`define T2_GEN_PRE_RESET   1
`define T2_FLAG_OVF        0
`define T2_FLAG_MATCH_A    1
`define T2_FLAG_MATCH_B    2

// ==========================================================================
// Timing counts
`define T2_COMMIT_EDGES    2
`define T2_FLAG_SYNC_STAGES 3

`endif

// File: design/timer2_pkg.sv
package timer2_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        WAVE_NORMAL,
        WAVE_PC_FF,
        WAVE_CTC,
        WAVE_FAST_FF,
        WAVE_RSVD4,
        WAVE_PC_A,
        WAVE_RSVD6,
        WAVE_FAST_A
    } wave_mode_t;

    typedef enum logic [2:0] {
        CS_STOP,
        CS_DIV1,
        CS_DIV8,
        CS_DIV32,
        CS_DIV64,
        CS_DIV128,
        CS_DIV256,
        CS_DIV1024
    } clock_select_t;

endpackage

// File: design/timer2_hold_reg.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer2_params.svh"

module timer2_hold_reg #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Processor side.
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // Timer source side.
    input  wire logic         async_mode,
    input  wire logic         osc_edge,
    // Commit towards the destination.
    output logic              commit,
    output logic [W-1:0]      commit_data,
    output logic              busy
);

    logic [W-1:0] held;
    logic [1:0]   edges;

    // A write in the commit cycle restarts the transfer, so the newer value wins.
    assign commit      = async_mode ? (busy && osc_edge && (edges == 2'(`T2_COMMIT_EDGES - 1))
                                       && !wr_en) : wr_en;
    assign commit_data = async_mode ? held : wr_data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held  <= '0;
            busy  <= 1'b0;
            edges <= 2'h0;
        end else if (wr_en) begin
            held  <= wr_data;
            busy  <= async_mode;
            edges <= 2'h0;
        end else if (!async_mode) begin
            busy  <= 1'b0;
            edges <= 2'h0;
        end else if (busy && osc_edge) begin
            busy  <= (edges != 2'(`T2_COMMIT_EDGES - 1));
            edges <= edges + 2'h1;
        end
    end

endmodule

`default_nettype wire

// File: design/timer2_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer2_params.svh"

module timer2_prescaler (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Source and control.
    input  wire logic       src_tick,
    input  wire logic       clear,
    input  wire logic [2:0] select,
    // Timer enable.
    output logic            timer_tick
);

    logic [9:0] div;
    wire        sel_stop = (select == timer2_pkg::CS_STOP);
    wire        sel_1    = (select == timer2_pkg::CS_DIV1);
    wire        sel_8    = (select == timer2_pkg::CS_DIV8);
    wire        sel_32   = (select == timer2_pkg::CS_DIV32);
    wire        sel_64   = (select == timer2_pkg::CS_DIV64);
    wire        sel_128  = (select == timer2_pkg::CS_DIV128);
    wire        sel_256  = (select == timer2_pkg::CS_DIV256);
    wire        wrap     = sel_1 ? 1'b1 :
                           sel_8 ? &div[2:0] :
                           sel_32 ? &div[4:0] :
                           sel_64 ? &div[5:0] :
                           sel_128 ? &div[6:0] :
                           sel_256 ? &div[7:0] : &div[9:0];

    assign timer_tick = src_tick && !sel_stop && wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 10'h000;
        end else if (clear) begin
            div <= 10'h000;
        end else if (src_tick) begin
            div <= div + 10'h001;
        end
    end

endmodule

`default_nettype wire

// File: design/async_timer2.sv
// Overview of operation
// - Async writes commit after two oscillator edges.
// - Five registers each own holding register.
// - Busy flag per register; no rewrite while busy.
// - Pending counter/compare write suppresses match.
// - Oscillator runs except deepest sleep modes.
// - Wake-up starts on next timer clock.
// - Counter read via register updated per edge.
// - Flag sync: three processor plus timer cycle.
// - Compare pin changes on timer clock.
// - Source defaults internal; select detaches pins.
// - Prescaler: 1,8,32,64,128,256,1024, stop.
// - Prescaler reset bit clears prescaler phase.
// - Nonzero output mode overrides port pin.
// - Non-PWM modes: off, toggle, clear, set.
// - Fast PWM: match and bottom actions.
// - Fast PWM compare equals top: bottom only.
// - Phase correct: up/down match actions.
// - Phase correct compare equals top: act at top.
// - Wave mode selects counting sequence and top.
// - Clock select field maps stop and divisions.
// - Fast PWM counts to top then zero.
// - Phase correct reverses at top and bottom, no hold.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "timer2_params.svh"

module async_timer2 (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillator and power.
    input  wire logic        osc_in_pin,
    input  wire logic        sleep_active,
    input  wire logic        deep_sleep,
    output logic             osc_run,
    output logic             osc_pins_detached,
    output logic             wake_request,
    // Channel A output.
    output logic             chan_a_compare_pin,
    output logic             chan_a_pin_override
);

    // ======================================================================
    // Bus decode
    wire access_wr   = psel && penable && pwrite;
    wire hit_ctrl_a  = (paddr == `T2_OFS_CTRL_A);
    wire hit_ctrl_b  = (paddr == `T2_OFS_CTRL_B);
    wire hit_count   = (paddr == `T2_OFS_COUNT);
    wire hit_cmp_a   = (paddr == `T2_OFS_CMP_A);
    wire hit_cmp_b   = (paddr == `T2_OFS_CMP_B);
    wire hit_status  = (paddr == `T2_OFS_STATUS);
    wire hit_general = (paddr == `T2_OFS_GENERAL);
    wire hit_flags   = (paddr == `T2_OFS_FLAGS);
    wire addr_hit    = hit_ctrl_a || hit_ctrl_b || hit_count || hit_cmp_a || hit_cmp_b
                       || hit_status || hit_general || hit_flags;
    wire wr_ctrl_a   = access_wr && hit_ctrl_a;
    wire wr_ctrl_b   = access_wr && hit_ctrl_b;
    wire wr_count    = access_wr && hit_count;
    wire wr_cmp_a    = access_wr && hit_cmp_a;
    wire wr_cmp_b    = access_wr && hit_cmp_b;
    wire wr_status   = access_wr && hit_status;
    wire wr_general  = access_wr && hit_general;
    wire wr_flags    = access_wr && hit_flags;
    wire timer2_pkg::byte_t wbyte = pwdata[7:0];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // ======================================================================
    // Registers and state
    timer2_pkg::byte_t timer2_control_a;
    timer2_pkg::byte_t timer2_control_b;
    timer2_pkg::byte_t count_value;
    timer2_pkg::byte_t compare_value_a;
    timer2_pkg::byte_t compare_value_b;
    timer2_pkg::byte_t count_readback;
    logic              async_clock_select;
    logic              count_up;
    logic              oc_a;
    logic [2:0]        flags;
    logic [2:0]        flag_d1;
    logic [2:0]        flag_d2;
    logic [2:0]        flag_d3;
    logic              wake_pending;
    logic              osc_s1;
    logic              osc_s2;
    logic              osc_s3;

    // ======================================================================
    // Oscillator edge detection
    // The first stage feeds only the second; the edge is taken after that.
    wire osc_edge = osc_s2 && !osc_s3;
    wire src_tick = async_clock_select ? osc_edge : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= osc_in_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // ======================================================================
    // Holding registers
    logic              cnt_commit;
    logic              cmpa_commit;
    logic              cmpb_commit;
    logic              ctla_commit;
    logic              ctlb_commit;
    timer2_pkg::byte_t cnt_data;
    timer2_pkg::byte_t cmpa_data;
    timer2_pkg::byte_t cmpb_data;
    timer2_pkg::byte_t ctla_data;
    timer2_pkg::byte_t ctlb_data;
    logic              cnt_busy;
    logic              cmpa_busy;
    logic              cmpb_busy;
    logic              ctla_busy;
    logic              ctlb_busy;

    // Each register has its own handshake so values move across whole.
    timer2_hold_reg #(.W(8)) u_hold_count (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_count),
        .wr_data     (wbyte),
        .async_mode  (async_clock_select),
        .osc_edge    (osc_edge),
        .commit      (cnt_commit),
        .commit_data (cnt_data),
        .busy        (cnt_busy)
    );

    timer2_hold_reg #(.W(8)) u_hold_cmp_a (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_cmp_a),
        .wr_data     (wbyte),
        .async_mode  (async_clock_select),
        .osc_edge    (osc_edge),
        .commit      (cmpa_commit),
        .commit_data (cmpa_data),
        .busy        (cmpa_busy)
    );

    timer2_hold_reg #(.W(8)) u_hold_cmp_b (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_cmp_b),
        .wr_data     (wbyte),
        .async_mode  (async_clock_select),
        .osc_edge    (osc_edge),
        .commit      (cmpb_commit),
        .commit_data (cmpb_data),
        .busy        (cmpb_busy)
    );

    timer2_hold_reg #(.W(8)) u_hold_ctrl_a (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_ctrl_a),
        .wr_data     (wbyte),
        .async_mode  (async_clock_select),
        .osc_edge    (osc_edge),
        .commit      (ctla_commit),
        .commit_data (ctla_data),
        .busy        (ctla_busy)
    );

    timer2_hold_reg #(.W(8)) u_hold_ctrl_b (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_ctrl_b),
        .wr_data     (wbyte),
        .async_mode  (async_clock_select),
        .osc_edge    (osc_edge),
        .commit      (ctlb_commit),
        .commit_data (ctlb_data),
        .busy        (ctlb_busy)
    );

    // ======================================================================
    // Prescaler
    logic timer_tick;

    timer2_prescaler u_prescaler (
        .pclk       (pclk),
        .presetn    (presetn),
        .src_tick   (src_tick),
        .clear      (wr_general && pwdata[`T2_GEN_PRE_RESET]),
        .select     (timer2_control_b[`T2_CS_HI:0]),
        .timer_tick (timer_tick)
    );

    // ======================================================================
    // Counting sequence
    wire timer2_pkg::wave_mode_t wave =
        timer2_pkg::wave_mode_t'({timer2_control_b[`T2_WAVE_BIT2], timer2_control_a[1:0]});
    wire       is_pc      = (wave == timer2_pkg::WAVE_PC_FF) || (wave == timer2_pkg::WAVE_PC_A);
    wire       is_fast    = (wave == timer2_pkg::WAVE_FAST_FF)
                            || (wave == timer2_pkg::WAVE_FAST_A);
    wire       top_from_a = (wave == timer2_pkg::WAVE_CTC) || (wave == timer2_pkg::WAVE_PC_A)
                            || (wave == timer2_pkg::WAVE_FAST_A);
    wire timer2_pkg::byte_t top = top_from_a ? compare_value_a : `T2_MAX;
    wire       at_top     = (count_value == top);
    wire       at_bottom  = (count_value == `T2_BOTTOM);
    // A pending counter or compare write blocks the match until it lands.
    wire       match_a    = timer_tick && (count_value == compare_value_a)
                            && !cnt_busy && !cmpa_busy;
    wire       match_b    = timer_tick && (count_value == compare_value_b)
                            && !cnt_busy && !cmpb_busy;
    wire       overflow   = timer_tick && (is_pc ? (at_bottom && !count_up) :
                                           is_fast ? at_top : (count_value == `T2_MAX));

    timer2_pkg::byte_t next_count;
    logic              next_up;

    always_comb begin
        next_count = count_value;
        next_up    = count_up;
        if (is_pc) begin
            if (count_up) begin
                next_up    = !at_top;
                next_count = at_top ? count_value - 8'h01 : count_value + 8'h01;
            end else begin
                next_up    = at_bottom;
                next_count = at_bottom ? count_value + 8'h01 : count_value - 8'h01;
            end
        end else begin
            next_count = at_top ? `T2_BOTTOM : count_value + 8'h01;
        end
    end

    // ======================================================================
    // Channel A waveform
    wire [1:0] com_a    = timer2_control_a[`T2_COM_A_HI:`T2_COM_A_LO];
    wire       special  = (compare_value_a == top) && com_a[1];
    wire       toggle_a = (com_a == 2'h1);
    logic      next_oc;

    always_comb begin
        next_oc = oc_a;
        if (is_fast) begin
            if (at_top && timer_tick && com_a[1]) begin
                next_oc = !com_a[0];
            end else if (match_a && !special) begin
                if (toggle_a && wave[2]) begin
                    next_oc = !oc_a;
                end else if (com_a[1]) begin
                    next_oc = com_a[0];
                end
            end
        end else if (is_pc) begin
            if (special && at_top && count_up && timer_tick) begin
                next_oc = !com_a[0];
            end else if (match_a && !special) begin
                if (toggle_a && wave[2]) begin
                    next_oc = !oc_a;
                end else if (com_a[1]) begin
                    next_oc = count_up ? com_a[0] : !com_a[0];
                end
            end
        end else if (match_a) begin
            if (toggle_a) begin
                next_oc = !oc_a;
            end else if (com_a[1]) begin
                next_oc = com_a[0];
            end
        end
    end

    // The pin follows the timer tick directly, never a processor-side copy.
    assign chan_a_compare_pin  = oc_a;
    assign chan_a_pin_override = |com_a;
    assign osc_pins_detached   = async_clock_select;
    // Only the deepest sleep states stop the crystal.
    assign osc_run             = async_clock_select && !deep_sleep;

    // ======================================================================
    // Timer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= `T2_RST_BYTE;
            count_up    <= 1'b1;
            oc_a        <= 1'b0;
        end else begin
            if (cnt_commit) begin
                count_value <= cnt_data;
            end else if (timer_tick) begin
                count_value <= next_count;
                count_up    <= next_up;
            end
            oc_a <= next_oc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer2_control_a   <= `T2_RST_BYTE;
            timer2_control_b   <= `T2_RST_BYTE;
            compare_value_a    <= `T2_RST_BYTE;
            compare_value_b    <= `T2_RST_BYTE;
            async_clock_select <= 1'b0;
        end else begin
            if (ctla_commit) timer2_control_a <= ctla_data;
            if (ctlb_commit) timer2_control_b <= ctlb_data;
            if (cmpa_commit) compare_value_a  <= cmpa_data;
            if (cmpb_commit) compare_value_b  <= cmpb_data;
            if (wr_status)   async_clock_select <= pwdata[`T2_ST_ASYNC];
        end
    end

    // Readback refreshes only on source edges, so stale values persist after wake.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_readback <= `T2_RST_BYTE;
        end else if (src_tick) begin
            count_readback <= count_value;
        end
    end

    // ======================================================================
    // Flags and wake
    wire [2:0] flag_evt = {match_b, match_a, overflow};
    wire [2:0] flag_set = async_clock_select ? flag_d3 : flag_evt;
    wire [2:0] flag_clr = wr_flags ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_d1 <= 3'h0;
            flag_d2 <= 3'h0;
            flag_d3 <= 3'h0;
            flags   <= 3'h0;
        end else begin
            flag_d1 <= flag_evt;
            flag_d2 <= flag_d1;
            flag_d3 <= flag_d2;
            flags   <= (flags & ~flag_clr) | flag_set;
        end
    end

    // The wake request waits one timer source edge, so the counter has moved on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_pending <= 1'b0;
            wake_request <= 1'b0;
        end else if (!sleep_active) begin
            wake_pending <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            if (|flag_evt) begin
                wake_pending <= 1'b1;
            end else if (wake_pending && src_tick) begin
                wake_pending <= 1'b0;
                wake_request <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Read data
    wire [7:0] status_byte = {2'b00, async_clock_select, cnt_busy, cmpa_busy, cmpb_busy,
                              ctla_busy, ctlb_busy};
    wire [7:0] rd_mux = hit_ctrl_a ? timer2_control_a :
                        hit_ctrl_b ? timer2_control_b :
                        hit_count  ? count_readback :
                        hit_cmp_a  ? compare_value_a :
                        hit_cmp_b  ? compare_value_b :
                        hit_status ? status_byte :
                        hit_flags  ? {5'h00, flags} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `T2_RST_WORD;
        end else if (psel && !penable) begin
            prdata <= {24'h000000, rd_mux};
        end
    end

endmodule

`default_nettype wire

// File: bench/async_timer2_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// Port checker for the timer block.
module async_timer2_chk (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Oscillator, power and pin.
    input wire logic        osc_in_pin,
    input wire logic        sleep_active,
    input wire logic        deep_sleep,
    input wire logic        osc_run,
    input wire logic        osc_pins_detached,
    input wire logic        wake_request,
    input wire logic        chan_a_compare_pin,
    input wire logic        chan_a_pin_override
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       osc_q;
    logic [3:0] since_rise;
    wire        acc = psel && penable;
    wire        bad = paddr < 12'h0B0 || paddr > 12'h0CC || paddr[1:0] != 2'h0;
    wire        rise = osc_in_pin && !osc_q;
    // The age counter saturates so that a stopped crystal never wraps it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q      <= 1'b0;
            since_rise <= 4'hF;
        end else begin
            osc_q      <= osc_in_pin;
            since_rise <= rise ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
        end
    end
    pready_high_a: assert property (pready) else $error("pready low");
    err_decode_a: assert property (acc |-> pslverr == bad) else $error("bad pslverr");
    err_idle_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
    upper_zero_a: assert property (acc |-> prdata[31:8] == 24'h0) else $error("prdata high");
    osc_run_a: assert property (osc_run == (osc_pins_detached && !deep_sleep))
        else $error("osc_run wrong");
    override_wr_a: assert property ($changed(chan_a_pin_override) && !osc_pins_detached
        |-> $past(acc && pwrite && paddr == 12'h0B0)) else $error("override without write");
    wake_clear_a: assert property (!sleep_active |=> !wake_request)
        else $error("wake stuck");
    pin_on_osc_a: assert property (osc_pins_detached && $past(osc_pins_detached)
        && $changed(chan_a_compare_pin) |-> since_rise < 4'h8) else $error("pin off osc");
endmodule
bind async_timer2 async_timer2_chk i_async_timer2_chk (.*);
`default_nettype wire

// File: bench/crystal_model.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// Crystal on the oscillator pins.
module crystal_model #(
    parameter int HALF_NS = 40
) (
    // Enable and clock.
    input  wire logic run,
    output var logic  osc_in_pin
);
    // Ten core cycles a period keeps the core well above four times faster.
    initial begin
        osc_in_pin = 1'b0;
        forever begin
            #(HALF_NS);
            osc_in_pin = run ? ~osc_in_pin : 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: bench/async_timer2_tb.sv
`timescale 1ns/1ns
`default_nettype none
module async_timer2_tb;
    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  cmp;
        logic [10:0] win;
        logic [10:0] high;
    } row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, osc_in_pin, osc_run, osc_pins_detached;
    logic        wake_request, chan_a_compare_pin, chan_a_pin_override;
    logic        sleep_active = 1'b0;
    logic        deep_sleep = 1'b0;
    logic        err;
    logic [7:0]  a, b;
    logic [10:0] hi;
    int          fails = 0, tests_run = 0, n;
    int          divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    row_t        rows [10] = '{
        '{8'h40, 8'h80, 11'h200, 11'h100}, '{8'h80, 8'h80, 11'h200, 11'h000},
        '{8'hC0, 8'h80, 11'h200, 11'h200}, '{8'h42, 8'h80, 11'h102, 11'h081},
        '{8'hB3, 8'h80, 11'h200, 11'h102}, '{8'hF3, 8'h80, 11'h200, 11'h0FE},
        '{8'hB3, 8'hFF, 11'h200, 11'h200}, '{8'hA1, 8'h80, 11'h3FC, 11'h200},
        '{8'hE1, 8'h80, 11'h3FC, 11'h1FC}, '{8'hA1, 8'hFF, 11'h3FC, 11'h3FC}};
    async_timer2 i_async_timer2 (.*);
    crystal_model i_crystal_model (.run(osc_run), .osc_in_pin(osc_in_pin));
    always #4 pclk = ~pclk;
    task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d,
                       output logic [7:0] r);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k == 16) fails++;
        r = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [7:0] d);
        logic [7:0] r;
        apb(1'b1, ad, d, r);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Equal sampling gaps of four prescaled periods make the step phase-free.
        for (int c = 0; c < 8; c++) begin
            wr(12'h0B4, 8'(c));
            apb(1'b0, 12'h0B8, 8'h00, a);
            repeat (divs[c] == 0 ? 29 : 4 * divs[c] - 3) @(posedge pclk);
            apb(1'b0, 12'h0B8, 8'h00, b);
            chk(8'(b - a), divs[c] == 0 ? 0 : 4);
        end
        // After a prescaler reset at divide-by-8 the first tick comes eight cycles later.
        wr(12'h0B4, 8'h02);
        wr(12'h0C8, 8'h02);
        apb(1'b0, 12'h0B8, 8'h00, a);
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h0B8, 8'h00, b);
        chk(8'(b - a), 0);
        apb(1'b0, 12'h0B8, 8'h00, b);
        chk(8'(b - a), 1);
        wr(12'h0B4, 8'h01);
        foreach (rows[i]) begin
            wr(12'h0BC, rows[i].cmp);
            wr(12'h0B0, rows[i].ctl);
            repeat (600) @(posedge pclk);
            hi = 11'h000;
            repeat (rows[i].win) begin
                @(negedge pclk);
                hi = hi + {10'h0, chan_a_compare_pin};
            end
            chk(hi, rows[i].high);
            chk(chan_a_pin_override, |rows[i].ctl[7:6]);
        end
        wr(12'h0C4, 8'h20);
        @(negedge pclk);
        chk(osc_pins_detached, 1'b1);
        wr(12'h0BC, 8'h33);
        wr(12'h0C0, 8'h44);
        apb(1'b0, 12'h0C4, 8'h00, a);
        chk(a, 8'h2C);
        n = 0;
        do begin
            apb(1'b0, 12'h0C4, 8'h00, a);
            n++;
        end while (a !== 8'h20 && n < 20);
        chk(n < 10, 1'b1);
        apb(1'b0, 12'h0BC, 8'h00, a);
        apb(1'b0, 12'h0C0, 8'h00, b);
        chk({a, b}, 16'h3344);
        wr(12'h0CC, 8'h07);
        sleep_active <= 1'b1;
        n = 0;
        while (wake_request !== 1'b1 && n < 6000) begin
            @(posedge pclk);
            n++;
        end
        chk(wake_request, 1'b1);
        apb(1'b0, 12'h0CC, 8'h00, a);
        chk(a != 8'h00, 1'b1);
        sleep_active <= 1'b0;
        deep_sleep   <= 1'b1;
        @(posedge pclk);
        chk(osc_run, 1'b0);
        deep_sleep <= 1'b0;
        presetn    <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int ad = 12'h0B0; ad <= 12'h0CC; ad += 4) begin
            apb(1'b0, 12'(ad), 8'h00, a);
            chk(a, 8'h00);
        end
        apb(1'b1, 12'h0D0, 8'hFF, a);
        chk(err, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
